/* File: rtl/gri_reg_stack.v */
`include "gri_map.vh"

// Operation
// - Acts as standard I2C slave; master keeps bit rate at or below 100kbps.
// - Answers address byte 0xA2 for writes and 0xA3 for reads.
// - First write byte after address is the stack pointer; data follows until Stop.
// - Acknowledge low after every byte written to our address; foreign address unanswered.
// - Pointer-only write loads pointer and changes no register.
// - Pointer advances by one after each written data byte, holding at 0x80.
// - Data written past 0x7F is acknowledged but discarded.
// - Read-only locations keep contents; time group writes go to time logic only.
// - Read starts at current pointer, left by pointer write, writes or reads.
// - Reads past 0x7F return zero.
// - Stop then Start, or repeated Start, both keep pointer between write and read.
// - Year 00 with month 01..12 enters setting mode; year write updates and saves.
// - Selector accepted only as 11, 12, 21 or 22; time fields unchecked.
// - Setting mode fills offset registers 0x3B..0x3F like a direct write.
// - Offset spans +/-23:59:59 at 1s steps, plus separate one hour DST.
module gri_reg_stack (
	input  wire       clock,      // 25 MHz device clock
	input  wire       nrst,       // Synchronous reset, active low
	input  wire       scl_i,      // Bus clock level
	input  wire       sda_i,      // Bus data level
	output wire       sda_o,      // Bus data drive value, always low
	output wire       sda_oe,     // High while pulling data low
	input  wire       sys_wr,     // Device side stack update strobe
	input  wire [6:0] sys_addr,   // Device side update location
	input  wire [7:0] sys_data,   // Device side update value
	output wire       time_wr,    // Pulse: master wrote a time group register
	output wire [6:0] time_addr,  // Time group location written
	output wire [7:0] time_data,  // Time group value written
	output wire       nvm_save,   // Pulse: offsets changed by setting mode
	output wire       bus_busy    // High from Start until Stop, foreign address or read NACK
);

	localparam S_IDLE  = 3'h0;
	localparam S_RX    = 3'h1;
	localparam S_RXEND = 3'h2;
	localparam S_ACK   = 3'h3;
	localparam S_TX    = 3'h4;
	localparam S_TXEND = 3'h5;
	localparam S_MACK  = 3'h6;
	localparam S_TXLD  = 3'h7;

	reg  [7:0] mem [0:`GRI_STACK_DEPTH-1];
	reg  [2:0] st_q;
	reg  [3:0] bit_q;
	reg  [7:0] sh_q, tx_q, ptr_q;
	reg        scl_q, sda_q, oe_q, is_addr_q, first_q, rw_q;
	reg        time_wr_q, nvm_save_q;
	reg  [6:0] time_addr_q;
	reg  [7:0] time_data_q, set_hr_q, set_mn_q, set_se_q, set_mon_q;
	reg  [7:0] setting_selector_code_q;
	integer    i;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function is_direct;
		input [6:0] a;
		begin
			is_direct = (a <= `GRI_CTL_LAST) ||
				(a >= `GRI_ALM_FIRST && a <= `GRI_ALM_LAST) ||
				(a >= `GRI_OFF_HOUR && a <= `GRI_OFF_RATE);
		end
	endfunction
	function is_time;
		input [6:0] a;
		begin
			is_time = (a >= `GRI_REG_SEC) && (a <= `GRI_REG_YEAR);
		end
	endfunction
	function [7:0] ptr_inc;
		input [7:0] p;
		begin
			ptr_inc = p[7] ? p : p + `GRI_PTR_ONE;
		end
	endfunction

	// ----------------------------------------------------------------
	// Bus condition detection
	// ----------------------------------------------------------------
	wire scl_rise = scl_i & ~scl_q;
	wire scl_fall = ~scl_i & scl_q;
	// Start and Stop are data edges while the bus clock stays high
	wire bus_start = scl_i & scl_q & sda_q & ~sda_i;
	wire bus_stop  = scl_i & scl_q & ~sda_q & sda_i;

	wire [7:0] rd_byte = ptr_q[7] ? `GRI_ZERO : mem[ptr_q[6:0]];

	wire sel_ok = (setting_selector_code_q[7:4] == `GRI_SEL_PLUS ||
		setting_selector_code_q[7:4] == `GRI_SEL_MINUS) &&
		(setting_selector_code_q[3:0] == `GRI_SEL_DST_OFF ||
		setting_selector_code_q[3:0] == `GRI_SEL_DST_ON);
	wire mon_ok = (set_mon_q >= `GRI_MON_LO && set_mon_q <= `GRI_MON_GAP_LO) ||
		(set_mon_q >= `GRI_MON_GAP_HI && set_mon_q <= `GRI_MON_HI);

	assign sda_o     = 1'b0;
	assign sda_oe    = oe_q;
	assign time_wr   = time_wr_q;
	assign time_addr = time_addr_q;
	assign time_data = time_data_q;
	assign nvm_save  = nvm_save_q;
	assign bus_busy  = (st_q != S_IDLE);

	// ----------------------------------------------------------------
	// Slave sequencer and stack
	// ----------------------------------------------------------------
	// standard slave
	always @(posedge clock) begin
		if (!nrst) begin
			st_q        <= S_IDLE;
			bit_q       <= `GRI_BIT_FIRST;
			sh_q        <= `GRI_ZERO;
			tx_q        <= `GRI_ZERO;
			ptr_q       <= `GRI_ZERO;
			scl_q       <= 1'b1;
			sda_q       <= 1'b1;
			oe_q        <= 1'b0;
			is_addr_q   <= 1'b0;
			first_q     <= 1'b0;
			rw_q        <= 1'b0;
			time_wr_q   <= 1'b0;
			time_addr_q <= `GRI_REG_SEC;
			time_data_q <= `GRI_ZERO;
			nvm_save_q  <= 1'b0;
			set_hr_q    <= `GRI_ZERO;
			set_mn_q    <= `GRI_ZERO;
			set_se_q    <= `GRI_ZERO;
			setting_selector_code_q <= `GRI_ZERO;
			set_mon_q   <= `GRI_ZERO;
			for (i = 0; i < `GRI_STACK_DEPTH; i = i + 1) begin
				mem[i] <= `GRI_ZERO;
			end
		end else begin
			scl_q      <= scl_i;
			sda_q      <= sda_i;
			time_wr_q  <= 1'b0;
			nvm_save_q <= 1'b0;
			// Device side updates lose to a master write in the same cycle
			if (sys_wr) begin
				mem[sys_addr] <= sys_data;
			end
			if (bus_start) begin
				st_q      <= S_RX;
				bit_q     <= `GRI_BIT_FIRST;
				is_addr_q <= 1'b1;
				first_q   <= 1'b0;
				oe_q      <= 1'b0;
			end else if (bus_stop) begin
				st_q <= S_IDLE;
				oe_q <= 1'b0;
			end else begin
				case (st_q)
				S_RX: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda_i};
						bit_q <= bit_q + 4'h1;
						if (bit_q == `GRI_BIT_LAST) begin
							st_q <= S_RXEND;
						end
					end
				end
				S_RXEND: begin
					if (scl_fall) begin
						if (is_addr_q) begin
							is_addr_q <= 1'b0;
							if (sh_q == `GRI_WR_ADDR) begin
								rw_q    <= 1'b0;
								first_q <= 1'b1;
								oe_q    <= 1'b1;
								st_q    <= S_ACK;
							end else if (sh_q == `GRI_RD_ADDR) begin
								rw_q <= 1'b1;
								oe_q <= 1'b1;
								st_q <= S_ACK;
							end else begin
								st_q <= S_IDLE;
							end
						end else begin
							oe_q <= 1'b1;
							st_q <= S_ACK;
							if (first_q) begin
								first_q <= 1'b0;
								ptr_q   <= sh_q;
							end else begin
								ptr_q <= ptr_inc(ptr_q);
								if (!ptr_q[7]) begin
									if (is_direct(ptr_q[6:0])) begin
										mem[ptr_q[6:0]] <= sh_q;
									end
									if (is_time(ptr_q[6:0])) begin
										time_wr_q   <= 1'b1;
										time_addr_q <= ptr_q[6:0];
										time_data_q <= sh_q;
									end
									case (ptr_q[6:0])
									`GRI_REG_SEC:  set_se_q <= sh_q;
									`GRI_REG_MIN:  set_mn_q <= sh_q;
									`GRI_REG_HOUR: set_hr_q <= sh_q;
									`GRI_REG_DAY:  setting_selector_code_q <= sh_q;
									`GRI_REG_MON:  set_mon_q <= sh_q;
									default: ;
									endcase
									if (ptr_q[6:0] == `GRI_REG_YEAR &&
										sh_q == `GRI_SET_YEAR && mon_ok && sel_ok) begin
										mem[`GRI_OFF_HOUR] <= (set_hr_q & `GRI_HOUR_MASK) |
											{(setting_selector_code_q[7:4] ==
											`GRI_SEL_MINUS), 7'h00};
										mem[`GRI_OFF_MIN]  <= set_mn_q;
										mem[`GRI_OFF_SEC]  <= set_se_q;
										mem[`GRI_OFF_DST]  <=
											(setting_selector_code_q[3:0] ==
											`GRI_SEL_DST_ON) ? `GRI_DST_ON : `GRI_DST_OFF;
										mem[`GRI_OFF_RATE] <= set_mon_q;
										nvm_save_q <= 1'b1;
									end
								end
							end
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						bit_q <= `GRI_BIT_FIRST;
						if (rw_q) begin
							tx_q  <= rd_byte;
							oe_q  <= ~rd_byte[7];
							ptr_q <= ptr_inc(ptr_q);
							st_q  <= S_TX;
						end else begin
							oe_q <= 1'b0;
							st_q <= S_RX;
						end
					end
				end
				S_TX: begin
					if (scl_rise) begin
						bit_q <= bit_q + 4'h1;
						if (bit_q == `GRI_BIT_LAST) begin
							st_q <= S_TXEND;
						end
					end else if (scl_fall) begin
						tx_q <= {tx_q[6:0], 1'b0};
						oe_q <= ~tx_q[6];
					end
				end
				S_TXEND: begin
					// Release data so the master can answer
					if (scl_fall) begin
						oe_q <= 1'b0;
						st_q <= S_MACK;
					end
				end
				S_MACK: begin
					if (scl_rise) begin
						st_q <= sda_i ? S_IDLE : S_TXLD;
					end
				end
				S_TXLD: begin
					if (scl_fall) begin
						bit_q <= `GRI_BIT_FIRST;
						tx_q  <= rd_byte;
						oe_q  <= ~rd_byte[7];
						ptr_q <= ptr_inc(ptr_q);
						st_q  <= S_TX;
					end
				end
				default: begin
					st_q <= S_IDLE;
				end
				endcase
			end
		end
	end
endmodule

/* File: rtl/gri_map.vh */
`ifndef GRI_MAP_VH
`define GRI_MAP_VH

// ----------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------
`define GRI_WR_ADDR     8'ha2
`define GRI_RD_ADDR     8'ha3
`define GRI_BIT_LAST    4'h7
`define GRI_BIT_FIRST   4'h0

// ----------------------------------------------------------------
// Stack layout
// ----------------------------------------------------------------
`define GRI_PTR_OOR     8'h80
`define GRI_PTR_ONE     8'h01
`define GRI_CTL_FIRST   7'h00
`define GRI_CTL_LAST    7'h01
`define GRI_REG_SEC     7'h02
`define GRI_REG_MIN     7'h03
`define GRI_REG_HOUR    7'h04
`define GRI_REG_DAY     7'h05
`define GRI_REG_WDAY    7'h06
`define GRI_REG_MON     7'h07
`define GRI_REG_YEAR    7'h08
`define GRI_ALM_FIRST   7'h09
`define GRI_ALM_LAST    7'h0f
`define GRI_OFF_HOUR    7'h3b
`define GRI_OFF_MIN     7'h3c
`define GRI_OFF_SEC     7'h3d
`define GRI_OFF_DST     7'h3e
`define GRI_OFF_RATE    7'h3f
`define GRI_STACK_DEPTH 128

// ----------------------------------------------------------------
// Setting mode codes
// ----------------------------------------------------------------
`define GRI_SET_YEAR    8'h00
`define GRI_MON_LO      8'h01
`define GRI_MON_HI      8'h12
`define GRI_MON_GAP_LO  8'h09
`define GRI_MON_GAP_HI  8'h10
`define GRI_SEL_PLUS    4'h1
`define GRI_SEL_MINUS   4'h2
`define GRI_SEL_DST_OFF 4'h1
`define GRI_SEL_DST_ON  4'h2
`define GRI_SIGN_BIT    7
`define GRI_HOUR_MASK   8'h3f
`define GRI_DST_ON      8'h01
`define GRI_DST_OFF     8'h00
`define GRI_ZERO        8'h00

`endif

/* File: tb/gri_master.sv */
// ----
// Bus master model
// ----
module gri_master (
	input  wire  clock,  // Device clock, paces the bus
	input  wire  sda,    // Resolved data line
	output logic scl,    // Bus clock drive
	output logic sda_m   // Data drive, 1 releases to pull-up
);
	timeunit 1ns;
	timeprecision 1ns;

	// Bus idles high until the first frame
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	task automatic hp;
		repeat (126) @(negedge clock);
	endtask

	task automatic sta;
		sda_m = 1'b1;
		hp;
		scl = 1'b1;
		hp;
		sda_m = 1'b0;
		hp;
		scl = 1'b0;
	endtask

	// Stop leaves both lines released
	task automatic sto;
		sda_m = 1'b0;
		hp;
		scl = 1'b1;
		hp;
		sda_m = 1'b1;
		hp;
	endtask

	// One bit, line sampled late in the high phase
	task automatic bt(input logic b, output logic r);
		sda_m = b;
		hp;
		scl = 1'b1;
		hp;
		r = sda;
		scl = 1'b0;
	endtask

	// Byte out, MSB first, then the slave's answer
	task automatic wb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bt(d[i], r);
		bt(1'b1, r);
		ack = ~r;
	endtask

	// acknowledge all but the last byte
	task automatic rb(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
		bt(last, r);
	endtask
endmodule

/* File: tb/gri_reg_stack_asserts.sv */
// ----
// Port checker
// ----
module gri_reg_stack_asserts (
	input wire       clock,      // Device clock
	input wire       nrst,       // Reset, active low
	input wire       scl_i,      // Bus clock level
	input wire       sda_o,      // Drive value
	input wire       sda_oe,     // Drive enable
	input wire       time_wr,    // Time group strobe
	input wire [6:0] time_addr,  // Time group location
	input wire [7:0] time_data,  // Time group value
	input wire       nvm_save,   // Save request
	input wire       bus_busy    // Transaction active
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	a_drive_low: assert property (sda_oe |-> sda_o == 1'b0)
		else $error("data driven high");
	a_idle_quiet: assert property (!bus_busy |-> !sda_oe)
		else $error("drive while idle");
	// data moves only while clock low
	a_oe_stable: assert property (scl_i && $past(scl_i) && $past(scl_i, 2) |-> $stable(sda_oe))
		else $error("drive moved in clock high");
	a_ack_low: assert property ($rose(sda_oe) |-> !scl_i)
		else $error("drive rose in clock high");
	a_busy_start: assert property ($rose(bus_busy) |-> scl_i)
		else $error("busy rose in clock low");
	a_time_range: assert property (time_wr |-> time_addr >= 7'h02 && time_addr <= 7'h08)
		else $error("time strobe off group");
	a_time_pulse: assert property (time_wr |=> !time_wr)
		else $error("time strobe too long");
	a_save_year: assert property (nvm_save |-> time_addr == 7'h08 && time_data == 8'h00 ##1 !nvm_save)
		else $error("save without year 00");

	cover property (nvm_save);
	cover property ($fell(bus_busy));
	cover property (time_wr && time_addr == 7'h08);
endmodule

bind gri_reg_stack gri_reg_stack_asserts u_chk (.clock(clock), .nrst(nrst), .scl_i(scl_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .time_wr(time_wr), .time_addr(time_addr),
	.time_data(time_data), .nvm_save(nvm_save), .bus_busy(bus_busy));

/* File: tb/gri_reg_stack_bench.sv */
// ----
// Bench top
// ----
module gri_reg_stack_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock = 1'b0, nrst = 1'b0, sys_wr = 1'b0;
	logic [6:0] sys_addr = 7'h00;
	logic [7:0] sys_data = 8'h00, tcnt = 8'h00, scnt = 8'h00;
	wire        scl, sda_m, sda_o, sda_oe, time_wr, nvm_save, bus_busy;
	wire  [6:0] time_addr;
	wire  [7:0] time_data;
	wire        sda_i = sda_m & ~sda_oe;  // Pull-up wins when nobody pulls
	int         error_cnt = 0, comparisons = 0;
	logic [7:0] sv [7] = '{8'h59, 8'h59, 8'h23, 8'h22, 8'h00, 8'h12, 8'h00};
	logic [7:0] ex [5] = '{8'ha3, 8'h59, 8'h59, 8'h01, 8'h12};

	gri_reg_stack u_dut (.clock(clock), .nrst(nrst), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o),
		.sda_oe(sda_oe), .sys_wr(sys_wr), .sys_addr(sys_addr), .sys_data(sys_data),
		.time_wr(time_wr), .time_addr(time_addr), .time_data(time_data),
		.nvm_save(nvm_save), .bus_busy(bus_busy));
	gri_master u_mst (.clock(clock), .sda(sda_i), .scl(scl), .sda_m(sda_m));

	initial forever #20 clock = ~clock;

	// Count strobes so tests can tell how many fired
	always @(posedge clock) begin
		if (time_wr) tcnt <= tcnt + 8'h01;
		if (nvm_save) scnt <= scnt + 8'h01;
	end

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask

	task automatic finish_test;
		$display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] d);
		logic a;
		u_mst.wb(d, a);
		chk({7'h00, a}, 8'h01);
	endtask

	task automatic rd(input logic last, input logic [7:0] e);
		logic [7:0] d;
		u_mst.rb(last, d);
		chk(d, e);
	endtask

	// Device side fill, only while the bus is idle
	task automatic sw(input logic [6:0] a, input logic [7:0] d);
		@(negedge clock);
		sys_addr = a;
		sys_data = d;
		sys_wr = 1'b1;
		@(negedge clock);
		sys_wr = 1'b0;
	endtask

	// Hang guard: the tests need about 90k cycles at 252 clocks per bit
	initial begin
		repeat (97000) @(posedge clock);
		error_cnt++;
		finish_test;
	end

	initial begin
		logic a;
		repeat (8) @(negedge clock);
		nrst = 1'b1;
		u_mst.sta; wr(8'ha2); wr(8'h02);
		foreach (sv[i]) wr(sv[i]);
		u_mst.sto;
		chk(tcnt, 8'h07);
		chk(scnt, 8'h01);
		chk({1'b0, time_addr}, 8'h08);
		chk(time_data, 8'h00);
		$display("setting test done");
		u_mst.sta; wr(8'ha2); wr(8'h3b); u_mst.sta; wr(8'ha3);
		for (int i = 0; i < 5; i++) rd(i == 4, ex[i]);
		u_mst.sto;
		sw(7'h40, 8'h5a);
		u_mst.sta; wr(8'ha3); rd(1'b1, 8'h5a); u_mst.sto;
		$display("readback test done");
		u_mst.sta; wr(8'ha2); wr(8'h05); wr(8'h13); wr(8'h00); wr(8'h01); wr(8'h00); u_mst.sto;
		chk(scnt, 8'h01);
		$display("bad selector test done");
		u_mst.sta; u_mst.wb(8'ha4, a);
		chk({7'h00, a}, 8'h00);
		chk({7'h00, bus_busy}, 8'h00);
		u_mst.sto;
		$display("foreign address test done");
		sw(7'h7e, 8'ha5); sw(7'h7f, 8'hc3);
		u_mst.sta; wr(8'ha2); wr(8'h7e); wr(8'h11); wr(8'h22); wr(8'h33); u_mst.sto;
		u_mst.sta; wr(8'ha2); wr(8'h7e); u_mst.sto;
		u_mst.sta; wr(8'ha3); rd(1'b0, 8'ha5); rd(1'b0, 8'hc3); rd(1'b1, 8'h00); u_mst.sto;
		chk(tcnt, 8'h0b);
		$display("stack top test done");
		finish_test;
	end
endmodule
